//--- design/rgb_pwm_pkg.sv
// package: constants and types for the serial rgb pwm driver
package rgb_pwm_pkg;
  localparam int LEVEL_W = 8;
  localparam int SHIFT_W = 32;
  localparam int CNT_W = 11;
  localparam int PER_W = 16;
  localparam logic [7:0] WRITE_COMMAND = 8'h3A;
  localparam int CMD_LSB = 24;
  localparam int CH0_LSB = 16;
  localparam int CH1_LSB = 8;
  localparam int CH2_LSB = 0;
  localparam logic [CNT_W-1:0] PWM_ON_COUNT = 11'h001;
  localparam logic [CNT_W-1:0] PWM_WRAP = 11'h7FF;
  localparam logic [PER_W-1:0] PER_MAX = 16'hFFFF;
  // bit period limits accepted from the host, in ns
  localparam int BIT_PERIOD_MIN_NS = 1660;
  localparam int BIT_PERIOD_MAX_NS = 50000;
  localparam int CLK_PERIOD_NS = 100;
  localparam int BIT_PERIOD_MAX_CYC = BIT_PERIOD_MAX_NS / CLK_PERIOD_NS;
  // idle-low holds expressed in bit periods
  localparam int END_PERIODS = 4;
  localparam int LATCH_PERIODS = 8;
  // gamma curve knees and offsets for the turn-off count
  localparam logic [7:0] GAMMA_KNEE_LOW = 8'h08;
  localparam logic [7:0] GAMMA_KNEE_HIGH = 8'h20;
  localparam logic [CNT_W-1:0] GAMMA_OFS_MID = 11'h00E;
  localparam logic [CNT_W-1:0] GAMMA_OFS_TOP = 11'h08A;

  typedef enum logic [1:0] {
    MEASURE_WAIT = 2'b00,
    MEASURE_RUN  = 2'b01,
    DATA         = 2'b10,
    FORWARD      = 2'b11
  } link_state_t;
endpackage

//--- design/serial_rgb_pwm_driver.sv
// module: single-wire serial three-channel gamma pwm led driver
`timescale 1ns/1ps
// What this block does
// - three independent 8-bit channel levels
// - pwm counter steps each grayscale clock once loaded
// - outputs on at count 1, zero stays off
// - output stays on while count within gamma on-time
// - latch load clears counter, forces outputs off
// - gamma mapping from level to on-time
// - outputs off after power-on until loaded
// - first two edges measure bit period
// - measurement shifts two zeros in
// - early second edge is one, late zero
// - end of sequence freezes, forwards input
// - long idle low loads latch, restarts pwm
// - msb first, load only if command 3Ah
// - bits 23:16, 15:8, 7:0 are channels 0,1,2
module serial_rgb_pwm_driver
  import rgb_pwm_pkg::*;
(
  input wire logic mclk_i,                  // 10 MHz system clock
  input wire logic rst_n_i,                 // power-on reset, active low
  input wire logic grayscale_ref_clock_i,   // grayscale reference tick, synchronous
  input wire logic serial_data_in_i,        // serial data input
  output logic serial_data_out_o,           // cascade serial output
  output logic [2:0] sink_on_o,             // channel sink outputs, high = on
  output logic [LEVEL_W-1:0] level_channel0_o,  // latched level, channel 0
  output logic [LEVEL_W-1:0] level_channel1_o,  // latched level, channel 1
  output logic [LEVEL_W-1:0] level_channel2_o   // latched level, channel 2
);

  typedef struct packed {
    link_state_t state;
    logic data_d;
    logic gck_d;
    logic [PER_W-1:0] bit_period;
    logic [PER_W-1:0] since_edge;
    logic [SHIFT_W-1:0] shift;
    logic [3*LEVEL_W-1:0] latch;
    logic [CNT_W-1:0] pwm_cnt;
    logic pwm_run;
    logic [2:0] sink;
    logic fwd_out;
  } state_t;

  state_t st_reg;
  state_t st_next;

  // ****************************************
  // gamma: turn-off count for a level
  // ****************************************
  function automatic logic [CNT_W-1:0] off_count(input logic [LEVEL_W-1:0] lv);
    logic [CNT_W-1:0] base;
    base = {3'h0, lv};
    if (lv < GAMMA_KNEE_LOW)
      off_count = CNT_W'(base << 1);
    else if (lv < GAMMA_KNEE_HIGH)
      off_count = CNT_W'((base << 2) - GAMMA_OFS_MID);
    else
      off_count = CNT_W'((base << 3) - GAMMA_OFS_TOP);
  endfunction

  function automatic logic [LEVEL_W-1:0] chan(input logic [3*LEVEL_W-1:0] l, input int lsb);
    chan = l[lsb +: LEVEL_W];
  endfunction

  function automatic logic in_frame(input link_state_t s);
    in_frame = (s == DATA) || (s == FORWARD);
  endfunction

  logic data_rise;
  logic gck_rise;
  logic frame_open;
  logic end_hit;
  logic latch_hit;
  logic [PER_W-1:0] end_lim;
  logic [PER_W-1:0] lat_lim;
  assign data_rise = serial_data_in_i & ~st_reg.data_d;
  assign gck_rise = grayscale_ref_clock_i & ~st_reg.gck_d;
  assign end_lim = PER_W'(st_reg.bit_period * END_PERIODS);
  assign lat_lim = PER_W'(st_reg.bit_period * LATCH_PERIODS);
  // idle-low timing only trusted once this sequence has its own bit period
  assign frame_open = in_frame(st_reg.state);
  assign end_hit = !serial_data_in_i && st_reg.since_edge >= end_lim;
  assign latch_hit = frame_open && !serial_data_in_i && st_reg.since_edge >= lat_lim;

  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    logic [LEVEL_W-1:0] lv;
    lv = '0;
    st_next = st_reg;
    st_next.data_d = serial_data_in_i;
    st_next.gck_d = grayscale_ref_clock_i;
    if (st_reg.since_edge != PER_MAX)
      st_next.since_edge = st_reg.since_edge + 16'h0001;
    if (data_rise)
      st_next.since_edge = '0;
    unique case (st_reg.state)
      MEASURE_WAIT:
        if (data_rise)
          st_next.state = MEASURE_RUN;
      MEASURE_RUN:
        if (data_rise)
        begin
          st_next.bit_period = st_reg.since_edge + 16'h0001;
          st_next.shift = {st_reg.shift[SHIFT_W-3:0], 2'b00};
          st_next.state = DATA;
        end
      DATA:
        if (data_rise)
          st_next.shift = {st_reg.shift[SHIFT_W-2:0], (st_reg.since_edge < (st_reg.bit_period >> 1))};
        else if (end_hit)
          st_next.state = FORWARD;
      FORWARD: ;
    endcase
    // latch hold beats end of sequence
    if (latch_hit)
    begin
      st_next.state = MEASURE_WAIT;
      if (st_reg.shift[SHIFT_W-1:CMD_LSB] == WRITE_COMMAND)
      begin
        st_next.latch = st_reg.shift[CMD_LSB-1:0];
        st_next.pwm_cnt = '0;
        st_next.pwm_run = 1'b1;
        st_next.sink = '0;
      end
    end
    else if (gck_rise && st_reg.pwm_run)
    begin
      st_next.pwm_cnt = (st_reg.pwm_cnt == PWM_WRAP) ? '0 : st_reg.pwm_cnt + 11'h001;
      for (int i = 0; i < 3; i++)
      begin
        lv = chan(st_reg.latch, CH0_LSB - i * LEVEL_W);
        if (lv == '0)
          st_next.sink[i] = 1'b0;
        else if (st_next.pwm_cnt == PWM_ON_COUNT)
          st_next.sink[i] = 1'b1;
        else if (st_next.pwm_cnt > off_count(lv))
          st_next.sink[i] = 1'b0;
      end
    end
    st_next.fwd_out = (st_reg.state == FORWARD) ? serial_data_in_i : 1'b0;
  end

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      st_reg <= '{state: MEASURE_WAIT, since_edge: PER_MAX, default: '0};
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign serial_data_out_o = st_reg.fwd_out;
  assign sink_on_o = st_reg.sink;
  assign level_channel0_o = st_reg.latch[CH0_LSB +: LEVEL_W];
  assign level_channel1_o = st_reg.latch[CH1_LSB +: LEVEL_W];
  assign level_channel2_o = st_reg.latch[CH2_LSB +: LEVEL_W];

  // ****************************************
  // checks
  // ****************************************
  off_at_reset_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    !st_reg.pwm_run |-> sink_on_o == 3'b000)
    else $error("sink on before any load");
  zero_level_off_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    level_channel0_o == 8'h00 |-> !sink_on_o[0])
    else $error("zero level channel lit");
  load_clears_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    $changed(st_reg.latch) |-> st_reg.pwm_cnt == '0 && sink_on_o == 3'b000)
    else $error("load did not clear pwm");
  load_needs_cmd_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    $changed(st_reg.latch) |-> $past(st_reg.shift[SHIFT_W-1:CMD_LSB]) == WRITE_COMMAND)
    else $error("latched without write command");
  bad_cmd_keep_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    latch_hit && st_reg.shift[SHIFT_W-1:CMD_LSB] != WRITE_COMMAND
    |=> $stable(st_reg.latch) && $stable(st_reg.pwm_run))
    else $error("levels loaded without write command");
  pwm_step_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    gck_rise && st_reg.pwm_run && st_reg.pwm_cnt == 11'h005 && st_next.state == st_reg.state
    |=> st_reg.pwm_cnt == 11'h006)
    else $error("pwm counter did not step");
  on_in_level_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    st_reg.pwm_cnt != '0 && level_channel2_o != 8'h00
    && st_reg.pwm_cnt <= off_count(level_channel2_o) |-> sink_on_o[2])
    else $error("channel off inside its on-time");
  off_past_level_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    st_reg.pwm_cnt > off_count(level_channel2_o) |-> !sink_on_o[2])
    else $error("channel on past its on-time");
  period_store_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    st_reg.state == MEASURE_RUN && data_rise |=> st_reg.bit_period == $past(st_reg.since_edge) + 16'h0001)
    else $error("bit period not stored");
  forward_copy_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    st_reg.state == FORWARD |=> serial_data_out_o == $past(serial_data_in_i))
    else $error("cascade output not forwarded");
  freeze_shift_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    st_reg.state == FORWARD ##1 st_reg.state == FORWARD |-> $stable(st_reg.shift))
    else $error("shift moved while forwarding");
  end_forward_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    st_reg.state == DATA && end_hit && !latch_hit |=> st_reg.state == FORWARD)
    else $error("end of sequence not taken");
  latch_return_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    latch_hit |=> st_reg.state == MEASURE_WAIT)
    else $error("latch hold did not restart measurement");
  measure_zeros_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    st_reg.state == MEASURE_RUN && data_rise |=> st_reg.shift[1:0] == 2'b00 && st_reg.state == DATA)
    else $error("measurement did not shift zeros");
  one_bit_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    st_reg.state == DATA && data_rise && st_reg.since_edge < (st_reg.bit_period >> 1)
    && st_next.state == DATA |=> st_reg.shift[0])
    else $error("early edge not decoded as one");
  on_at_one_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    $rose(st_reg.pwm_cnt == PWM_ON_COUNT) && level_channel1_o != 8'h00 |-> sink_on_o[1])
    else $error("channel not on at count one");

endmodule

//--- tb/host_serial_model.sv
// host side model driving the single-wire serial link
`timescale 1ns/1ps
module host_serial_model
(
  input wire logic mclk_i,   // system clock
  output logic serial_data_o // serial line, pulled low when idle
);
  // ****
  // line driving
  // ****
  localparam int BIT_PERIOD = 20;
  initial serial_data_o = 1'b0;
  // next rising edge lands gap cycles after the last one
  task automatic edge_after(input int gap);
    repeat (gap - 2) @(negedge mclk_i);
    serial_data_o = 1'b1;
    repeat (2) @(negedge mclk_i);
    serial_data_o = 1'b0;
  endtask
  task automatic send_packet(input logic [31:0] pkt);
    edge_after(BIT_PERIOD);
    edge_after(BIT_PERIOD);
    for (int i = 29; i >= 0; i--)
      edge_after(pkt[i] ? BIT_PERIOD / 4 : BIT_PERIOD);
  endtask
  task automatic hold_low(input int periods);
    repeat (periods * BIT_PERIOD) @(negedge mclk_i);
  endtask
endmodule

//--- tb/testbench.sv
// self-checking bench for the serial rgb pwm driver
`timescale 1ns/1ps
module testbench;
  import rgb_pwm_pkg::*;
  typedef struct packed {logic [23:0] lv; logic [10:0] g0; logic [10:0] g1; logic [10:0] g2;} row_t;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic grayscale_ref_clock = 1'b0;
  logic serial_data_in;
  logic serial_data_out;
  logic [2:0] sink;
  logic [LEVEL_W-1:0] lv0, lv1, lv2;
  logic [31:0] fwd;
  int n_fail = 0;
  int n_tests = 0;
  row_t rows [3] = '{'{24'h010280, 11'h002, 11'h004, 11'h376},
                     '{24'hFF0007, 11'h76E, 11'h000, 11'h00E},
                     '{24'h081F20, 11'h012, 11'h06E, 11'h076}};
  initial forever #50 mclk_i = ~mclk_i;
  initial forever
  begin
    repeat (2) @(negedge mclk_i);
    grayscale_ref_clock = ~grayscale_ref_clock;
  end
  host_serial_model host (.mclk_i(mclk_i), .serial_data_o(serial_data_in));
  serial_rgb_pwm_driver i_serial_rgb_pwm_driver (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .grayscale_ref_clock_i(grayscale_ref_clock), .serial_data_in_i(serial_data_in),
    .serial_data_out_o(serial_data_out),
    .sink_on_o(sink), .level_channel0_o(lv0), .level_channel1_o(lv1), .level_channel2_o(lv2));
  // ****
  // checking helpers
  // ****
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: saw %0h, wanted %0h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    if (n_fail == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // on-cycles over one full pwm period, four mclk per tick
  task automatic pwm_on(input row_t r);
    logic [31:0] c [3];
    c = '{default: 0};
    repeat ((int'(PWM_WRAP) + 1) * 4) @(negedge mclk_i)
      for (int k = 0; k < 3; k++) c[k] += 32'(sink[k] === 1'b1);
    check(c[0], 4 * r.g0);
    check(c[1], 4 * r.g1);
    check(c[2], 4 * r.g2);
  endtask
  // ****
  // main sequence
  // ****
  initial
  begin
    repeat (20) @(negedge mclk_i);
    rst_n_i = 1'b1;
    check({sink, lv0, lv1, lv2}, 32'h0);
    foreach (rows[i])
    begin
      host.send_packet({WRITE_COMMAND, rows[i].lv});
      host.hold_low(10);
      check({lv0, lv1, lv2}, rows[i].lv);
      pwm_on(rows[i]);
    end
    host.send_packet({8'h3B, 24'h123456});
    host.hold_low(10);
    check({lv0, lv1, lv2}, rows[2].lv);
    // cascade: own packet kept, second one forwarded
    host.send_packet({WRITE_COMMAND, 24'hA5015A});
    host.hold_low(5);
    fwd = 0;
    fork
      begin
        host.send_packet({WRITE_COMMAND, 24'h000000});
        host.hold_low(10);
      end
      repeat (1500) @(negedge mclk_i) fwd += 32'(serial_data_out === 1'b1);
    join
    check(fwd, 32'd64);
    check({lv0, lv1, lv2}, 24'hA5015A);
    rst_n_i = 1'b0;
    @(negedge mclk_i);
    check({sink, lv0, lv1, lv2}, 32'h0);
    rst_n_i = 1'b1;
    check({sink, lv0, lv1, lv2}, 32'h0);
    host.send_packet({WRITE_COMMAND, 24'h00FF01});
    host.hold_low(10);
    check({lv0, lv1, lv2}, 24'h00FF01);
    conclude();
  end
  initial
  begin
    repeat (50000) @(posedge mclk_i);
    n_fail++;
    conclude();
  end
endmodule
